// file: logic/mei_defs.vh
// Constants for the motion event interrupt block
`ifndef MEI_DEFS_VH
`define MEI_DEFS_VH
`define MEI_ADDR_W        8
`define MEI_REG_FREEFALL_ACCEL_THRESHOLD    8'h00
`define MEI_REG_FREEFALL_DURATION_THRESHOLD    8'h04
`define MEI_REG_MOTION_ACCEL_THRESHOLD   8'h08
`define MEI_REG_MOTION_DURATION_THRESHOLD   8'h0c
`define MEI_REG_ST_THR    8'h10
`define MEI_REG_ST_DUR    8'h14
`define MEI_REG_DEC_CTRL  8'h18
`define MEI_REG_PIN_CFG   8'h1c
`define MEI_REG_INT_EN    8'h20
`define MEI_REG_INT_STAT  8'h24
`define MEI_REG_DET_STAT  8'h28
`define MEI_REG_HPF_CFG   8'h2c
// Source bit positions in enable and status
`define MEI_SRC_READY     0
`define MEI_SRC_AUX_DONE  1
`define MEI_SRC_AUX_ERR   2
`define MEI_SRC_FIFO_OVF  3
`define MEI_SRC_CLK_LOCK  4
`define MEI_SRC_STILL     5
`define MEI_SRC_MOTION    6
`define MEI_SRC_FALL      7
`define MEI_NSRC          8
// Pin configuration bits
`define MEI_PIN_ACT_LOW   0
`define MEI_PIN_OPEN_DRN  1
`define MEI_PIN_LATCH     2
`define MEI_PIN_ANY_RD    3
// Decrement modes
`define MEI_DEC_RESET     2'h0
`define MEI_DEC_ONE       2'h1
`define MEI_DEC_TWO       2'h2
`define MEI_DEC_FOUR      2'h3
`define MEI_RESP_OKAY     2'h0
`define MEI_RESP_SLVERR   2'h2
`endif

// file: logic/mei_top.v
// Motion event detectors, interrupt flags and AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "mei_defs.vh"
module mei_top (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Sample stream, signed 16-bit counts, 1 count = 1 mg
    input  wire        sample_valid,
    input  wire [15:0] accel_x,
    input  wire [15:0] accel_y,
    input  wire [15:0] accel_z,
    // Other interrupt source events, one-cycle pulses
    input  wire        fifo_overflow,
    input  wire        aux_master_error,
    input  wire        aux_slave4_done,
    input  wire        clock_locked,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Interrupt pin
    output reg         int_out,
    output reg         int_oe
);

////////////////////////////////////////////////////////////////////////
// Registers
reg  [7:0]  freefall_accel_threshold;
reg  [7:0]  freefall_duration_threshold;
reg  [7:0]  motion_accel_threshold;
reg  [7:0]  motion_duration_threshold;
reg  [7:0]  still_accel_threshold;
reg  [7:0]  still_duration_threshold;
reg  [3:0]  detector_decrement_control;
reg  [3:0]  pin_cfg;
reg  [7:0]  int_enable;
reg  [7:0]  int_status;
reg  [2:0]  hpf_shift;
reg  [7:0]  ff_cnt;
reg  [7:0]  mot_cnt;
reg  [7:0]  st_cnt;
reg         ff_flag;
reg         mot_flag;
reg         still_state;
reg         aw_hold;
reg         w_hold;
reg  [7:0]  aw_addr;
reg  [31:0] w_data;
reg  [3:0]  w_strb;

////////////////////////////////////////////////////////////////////////
// High pass filter: running mean subtracted per axis, rate set by hpf_shift
wire [47:0] raw = {accel_z, accel_y, accel_x};
wire [2:0]  abs_lt_ff;
wire [2:0]  hp_gt_mot;
wire [2:0]  hp_lt_st;
genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
        reg  [23:0] mean;
        wire signed [15:0] s = raw[16*g+15:16*g];
        wire signed [23:0] se = {{8{s[15]}}, s};
        wire signed [23:0] hp = se - $signed(mean);
        wire [15:0] a  = s[15] ? (~s + 16'h0001) : s;
        wire [23:0] ha = hp[23] ? (~hp + 24'h000001) : hp;
        always @(posedge sys_clk) begin
            if (rst) begin
                mean <= 24'h000000;
            end else if (sample_valid) begin
                // Signed sum keeps the shift arithmetic for negative steps
                mean <= $unsigned($signed(mean) + (hp >>> hpf_shift));
            end
        end
        assign abs_lt_ff[g] = a < {8'h00, freefall_accel_threshold};
        assign hp_gt_mot[g] = ha > {16'h0000, motion_accel_threshold};
        assign hp_lt_st[g]  = ha < {16'h0000, still_accel_threshold};
    end
endgenerate

wire ff_hit  = &abs_lt_ff;
wire mot_hit = |hp_gt_mot;
wire st_hit  = &hp_lt_st;

////////////////////////////////////////////////////////////////////////
// Counter step: saturating up, mode-selected down
function [7:0] mei_step;
    input [7:0] cnt;
    input [7:0] thr;
    input       hit;
    input [1:0] mode;
    reg   [7:0] dec;
    begin
        dec = 8'h00;
        case (mode)
            `MEI_DEC_ONE:  dec = 8'h01;
            `MEI_DEC_TWO:  dec = 8'h02;
            `MEI_DEC_FOUR: dec = 8'h04;
            default:       dec = cnt;
        endcase
        if (hit)
            mei_step = (cnt >= thr) ? thr : cnt + 8'h01;
        else
            mei_step = (cnt <= dec) ? 8'h00 : cnt - dec;
    end
endfunction

// Durations count samples; one sample per ms at a 1 kHz rate
wire [7:0] next_ff_cnt  = mei_step(ff_cnt, freefall_duration_threshold,
                          ff_hit, detector_decrement_control[1:0]);
wire [7:0] next_mot_cnt = mei_step(mot_cnt, motion_duration_threshold,
                          mot_hit, detector_decrement_control[3:2]);
wire [7:0] next_st_cnt  = mot_hit ? 8'h00 : (st_hit ?
                          ((st_cnt >= still_duration_threshold) ?
                          still_duration_threshold : st_cnt + 8'h01)
                          : st_cnt);

wire ff_reach  = next_ff_cnt == freefall_duration_threshold &&
                 freefall_duration_threshold != 8'h00;
wire mot_reach = next_mot_cnt == motion_duration_threshold &&
                 motion_duration_threshold != 8'h00;
wire st_reach  = next_st_cnt == still_duration_threshold &&
                 still_duration_threshold != 8'h00;
wire st_change = sample_valid && (st_reach != still_state);

wire ff_rise  = sample_valid && ff_reach && !ff_flag;
wire mot_rise = sample_valid && mot_reach && !mot_flag;

////////////////////////////////////////////////////////////////////////
// AXI4-Lite handshakes
wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take  = s_axi_wvalid && s_axi_wready;
wire have_aw = aw_hold || aw_take;
wire have_w  = w_hold || w_take;
wire wr_go   = have_aw && have_w && !s_axi_bvalid;
wire [7:0]  wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
wire [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
wire [3:0]  wr_strb = w_hold ? w_strb : s_axi_wstrb;
wire wr_lane = wr_go && wr_strb[0];
wire rd_go   = s_axi_arvalid && s_axi_arready;
wire rd_stat = rd_go && s_axi_araddr == `MEI_REG_INT_STAT;
wire rd_det  = rd_go && s_axi_araddr == `MEI_REG_DET_STAT;

// Clear on status read, or any read when so configured
wire clr_all = pin_cfg[`MEI_PIN_LATCH] &&
               (rd_stat || (pin_cfg[`MEI_PIN_ANY_RD] && rd_go));
wire clr_det = rd_det || clr_all;

////////////////////////////////////////////////////////////////////////
// Source events and status flags; set wins over clear
wire [7:0] events;
assign events[`MEI_SRC_READY]    = sample_valid;
assign events[`MEI_SRC_AUX_DONE] = aux_slave4_done;
assign events[`MEI_SRC_AUX_ERR]  = aux_master_error;
assign events[`MEI_SRC_FIFO_OVF] = fifo_overflow;
assign events[`MEI_SRC_CLK_LOCK] = clock_locked;
assign events[`MEI_SRC_STILL]    = st_change;
assign events[`MEI_SRC_MOTION]   = mot_rise;
assign events[`MEI_SRC_FALL]     = ff_rise;

reg [7:0] next_int_status;
always @* begin
    if (pin_cfg[`MEI_PIN_LATCH])
        next_int_status = (clr_all ? 8'h00 : int_status) | events;
    else
        next_int_status = events; // Unlatched: one pulse per event
end

always @(posedge sys_clk) begin
    if (rst) begin
        ff_cnt      <= 8'h00;
        mot_cnt     <= 8'h00;
        st_cnt      <= 8'h00;
        ff_flag     <= 1'b0;
        mot_flag    <= 1'b0;
        still_state <= 1'b0;
        int_status  <= 8'h00;
    end else begin
        int_status <= next_int_status;
        if (sample_valid) begin
            ff_cnt  <= next_ff_cnt;
            mot_cnt <= next_mot_cnt;
            st_cnt  <= next_st_cnt;
            still_state <= st_reach;
        end
        if (ff_rise)
            ff_flag <= 1'b1;
        else if (sample_valid && next_ff_cnt == 8'h00)
            ff_flag <= 1'b0;
        if (mot_rise)
            mot_flag <= 1'b1;
        else if (clr_det)
            mot_flag <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Interrupt pin: polarity and push-pull or open-drain
wire any_int = |(int_status & int_enable);
always @(posedge sys_clk) begin
    if (rst) begin
        int_out <= 1'b0;
        int_oe  <= 1'b1;
    end else begin
        int_out <= any_int ^ pin_cfg[`MEI_PIN_ACT_LOW];
        int_oe  <= !pin_cfg[`MEI_PIN_OPEN_DRN] ||
                   (any_int ^ pin_cfg[`MEI_PIN_ACT_LOW]) == 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Write channel
always @(posedge sys_clk) begin
    if (rst) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `MEI_RESP_OKAY;
        aw_hold       <= 1'b0;
        w_hold        <= 1'b0;
        aw_addr       <= 8'h00;
        w_data        <= 32'h00000000;
        w_strb        <= 4'h0;
        freefall_accel_threshold    <= 8'h00;
        freefall_duration_threshold <= 8'h00;
        motion_accel_threshold      <= 8'h00;
        motion_duration_threshold   <= 8'h00;
        still_accel_threshold       <= 8'h00;
        still_duration_threshold    <= 8'h00;
        detector_decrement_control  <= 4'h0;
        pin_cfg    <= 4'h4;
        int_enable <= 8'h00;
        hpf_shift  <= 3'h4;
    end else begin
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (aw_take && !wr_go) begin
            aw_hold       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (w_take && !wr_go) begin
            w_hold       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= `MEI_RESP_OKAY;
            case (wr_addr)
                `MEI_REG_FREEFALL_ACCEL_THRESHOLD: if (wr_lane)
                    freefall_accel_threshold <= wr_data[7:0];
                `MEI_REG_FREEFALL_DURATION_THRESHOLD: if (wr_lane)
                    freefall_duration_threshold <= wr_data[7:0];
                `MEI_REG_MOTION_ACCEL_THRESHOLD: if (wr_lane)
                    motion_accel_threshold <= wr_data[7:0];
                `MEI_REG_MOTION_DURATION_THRESHOLD: if (wr_lane)
                    motion_duration_threshold <= wr_data[7:0];
                `MEI_REG_ST_THR: if (wr_lane)
                    still_accel_threshold <= wr_data[7:0];
                `MEI_REG_ST_DUR: if (wr_lane)
                    still_duration_threshold <= wr_data[7:0];
                `MEI_REG_DEC_CTRL: if (wr_lane)
                    detector_decrement_control <= wr_data[3:0];
                `MEI_REG_PIN_CFG: if (wr_lane)
                    pin_cfg <= wr_data[3:0];
                `MEI_REG_INT_EN: if (wr_lane)
                    int_enable <= wr_data[7:0];
                `MEI_REG_HPF_CFG: if (wr_lane)
                    hpf_shift <= wr_data[2:0];
                `MEI_REG_INT_STAT, `MEI_REG_DET_STAT: ;
                default: s_axi_bresp <= `MEI_RESP_SLVERR;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read channel
reg [31:0] rd_word;
reg        rd_ok;
always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `MEI_REG_FREEFALL_ACCEL_THRESHOLD:   rd_word = {24'h000000, freefall_accel_threshold};
        `MEI_REG_FREEFALL_DURATION_THRESHOLD:   rd_word = {24'h000000, freefall_duration_threshold};
        `MEI_REG_MOTION_ACCEL_THRESHOLD:  rd_word = {24'h000000, motion_accel_threshold};
        `MEI_REG_MOTION_DURATION_THRESHOLD:  rd_word = {24'h000000, motion_duration_threshold};
        `MEI_REG_ST_THR:   rd_word = {24'h000000, still_accel_threshold};
        `MEI_REG_ST_DUR:   rd_word = {24'h000000, still_duration_threshold};
        `MEI_REG_DEC_CTRL: rd_word = {28'h0000000, detector_decrement_control};
        `MEI_REG_PIN_CFG:  rd_word = {28'h0000000, pin_cfg};
        `MEI_REG_INT_EN:   rd_word = {24'h000000, int_enable};
        `MEI_REG_INT_STAT: rd_word = {24'h000000, int_status};
        `MEI_REG_DET_STAT: rd_word = {29'h00000000, mot_flag,
                                      ff_flag, still_state};
        `MEI_REG_HPF_CFG:  rd_word = {29'h00000000, hpf_shift};
        default: begin
            rd_word = 32'h00000000;
            rd_ok   = 1'b0;
        end
    endcase
end

always @(posedge sys_clk) begin
    if (rst) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `MEI_RESP_OKAY;
    end else begin
        if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `MEI_RESP_OKAY : `MEI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule // mei_top

// file: sim/mei_top_sva.sv
// Checker for bus handshakes and interrupt pin of the event block
`timescale 1ns/1ps
`include "mei_defs.vh"
module mei_top_sva (
    // Clock and reset
    input logic        sys_clk,
    input logic        rst,
    // Write channels
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    // Read channels
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    // Interrupt pin
    input logic        int_out,
    input logic        int_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    chk_reset_idle: assert property (
        $fell(rst) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
            && !s_axi_rvalid && !int_out && int_oe)
        else $error("bus or pin busy after reset");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid)
        else $error("write not answered");
    chk_err_zero: assert property (
        s_axi_rvalid && s_axi_rresp == `MEI_RESP_SLVERR |-> s_axi_rdata == 0)
        else $error("error read carries data");
    chk_r_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read channel not released");
    chk_pin_drive: assert property (
        !int_out |-> int_oe)
        else $error("pin low but not driven");
endmodule // mei_top_sva

// file: sim/mei_host.sv
// Partner model: host processor on the AXI4-Lite register bus
`timescale 1ns/1ps
module mei_host (
    // Clock
    input  logic        sys_clk,
    // Write channels
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    input  logic [1:0]  s_axi_bresp,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    // Read channels
    output logic [7:0]  s_axi_araddr,
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    input  logic [31:0] s_axi_rdata,
    input  logic [1:0]  s_axi_rresp,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_wdata} = 34'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'hf;
    end
    ////////////////////////////////////////
    task automatic write(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r, output logic t);
        int n;
        n = 0;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            n++;
            // Released payload is scrambled, not left standing
            if (s_axi_awvalid && s_axi_awready) begin
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            end
        end while (!s_axi_bvalid && n < 50);
        {r, t} = {s_axi_bresp, !s_axi_bvalid};
        s_axi_bready <= 1'b0;
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r, output logic t);
        int n;
        n = 0;
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            end
        end while (!s_axi_rvalid && n < 50);
        {d, r, t} = {s_axi_rdata, s_axi_rresp, !s_axi_rvalid};
        s_axi_rready <= 1'b0;
    endtask
endmodule // mei_host

// file: sim/motion_event_interrupts_bench.sv
// Testbench for the motion event interrupt block
`timescale 1ns/1ps
`include "mei_defs.vh"
module motion_event_interrupts_bench;
    localparam logic [1:0] OK = `MEI_RESP_OKAY;
    localparam logic [7:0] DET = `MEI_REG_DET_STAT;
    localparam logic [7:0] STA = `MEI_REG_INT_STAT;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        sample_valid = 1'b0;
    logic [15:0] accel_x = 16'h0, accel_y = 16'h0, accel_z = 16'h0;
    logic        fifo_overflow = 1'b0, aux_master_error = 1'b0;
    logic        aux_slave4_done = 1'b0, clock_locked = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, int_out, int_oe;
    int          bad_count = 0;
    int          compares = 0;
    always #5 sys_clk = ~sys_clk;
    mei_top  u_mei_top  (.*);
    mei_host u_mei_host (.*);
    ////////////////////////////////////////
    task automatic summarize();
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = OK);
        logic [1:0] r;
        logic       t;
        u_mei_host.write(a, d, r, t);
        check(!t && r === er, $sformatf("write %h", a));
        if (t) summarize();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                      input logic [1:0] er = OK);
        logic [31:0] d;
        logic [1:0]  r;
        logic        t;
        u_mei_host.read(a, d, r, t);
        check(!t && (d & m) === e && r === er, $sformatf("read %h", a));
        if (t) summarize();
    endtask
    task automatic samp(input int x, y, z);
        @(posedge sys_clk);
        {sample_valid, accel_x, accel_y, accel_z} <= {1'b1, 16'(x),
                                                      16'(y), 16'(z)};
        @(posedge sys_clk);
        sample_valid <= 1'b0;
    endtask
    task automatic ev(input logic [3:0] v);
        @(posedge sys_clk);
        {fifo_overflow, aux_master_error, aux_slave4_done, clock_locked} <= v;
        @(posedge sys_clk);
        {fifo_overflow, aux_master_error, aux_slave4_done, clock_locked} <= 0;
    endtask
    task automatic pin(input logic e);
        repeat (3) @(posedge sys_clk);
        check(int_out === e, "pin level");
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        rd(`MEI_REG_PIN_CFG, 32'h4, 32'hf);
        rd(`MEI_REG_HPF_CFG, 32'h4, 32'h7);
        wr(`MEI_REG_FREEFALL_ACCEL_THRESHOLD, 32'h64);
        rd(`MEI_REG_FREEFALL_ACCEL_THRESHOLD, 32'h64, 32'hff);
        wr(8'h30, 32'h1, `MEI_RESP_SLVERR);
        rd(8'h30, 32'h0, 32'hffffffff, `MEI_RESP_SLVERR);
        wr(STA, 32'hff);
        rd(STA, 32'h0, 32'hff);
    endtask
    task automatic t_sources();
        logic [7:0] bit_of [4] = '{8'h10, 8'h02, 8'h04, 8'h08};
        wr(`MEI_REG_INT_EN, 32'hff);
        for (int k = 0; k < 4; k++) begin
            ev(4'(1 << k));
            pin(1'b1);
            rd(STA, 32'(bit_of[k]), 32'hfe);
            pin(1'b0);
        end
        wr(`MEI_REG_INT_EN, 32'hf7);
        ev(4'h8);
        pin(1'b0);
        wr(`MEI_REG_INT_EN, 32'hff);
        pin(1'b1);
        rd(STA, 32'h08, 32'hff);
        wr(`MEI_REG_PIN_CFG, 32'h5);
        pin(1'b1);
        wr(`MEI_REG_PIN_CFG, 32'h6);
        ev(4'h8);
        pin(1'b1);
        check(int_oe === 1'b0, "pin not released");
        rd(STA, 32'h08, 32'hff);
        wr(`MEI_REG_PIN_CFG, 32'h4);
    endtask
    task automatic t_fall();
        wr(`MEI_REG_FREEFALL_DURATION_THRESHOLD, 32'd3);
        wr(`MEI_REG_DEC_CTRL, 32'h1);
        samp(0, 0, 500);
        samp(50, -50, 99);
        samp(0, 0, 0);
        rd(DET, 32'h0, 32'h2);
        samp(0, 0, 0);
        rd(DET, 32'h2, 32'h2);
        rd(STA, 32'h80, 32'h80);
        samp(0, 0, 0);
        samp(0, 0, 100);
        rd(DET, 32'h2, 32'h2);
        samp(-200, 0, 0);
        samp(0, 300, 0);
        rd(DET, 32'h0, 32'h2);
        for (int m = 0; m < 4; m++) begin
            if (m == 1) continue;
            wr(`MEI_REG_DEC_CTRL, 32'(m));
            repeat (3) samp(0, 0, 0);
            samp(0, 0, 400);
            rd(DET, (m == 2) ? 32'h2 : 32'h0, 32'h2);
            samp(0, 0, 400);
            rd(DET, 32'h0, 32'h2);
        end
        wr(`MEI_REG_FREEFALL_DURATION_THRESHOLD, 32'd0);
    endtask
    task automatic t_motion();
        wr(`MEI_REG_MOTION_ACCEL_THRESHOLD, 32'd50);
        wr(`MEI_REG_MOTION_DURATION_THRESHOLD, 32'd2);
        wr(`MEI_REG_DEC_CTRL, 32'h4);
        samp(1000, 0, 0);
        rd(DET, 32'h0, 32'h4);
        samp(0, 0, -1000);
        rd(DET, 32'h4, 32'h4);
        rd(DET, 32'h0, 32'h4);
        rd(STA, 32'h40, 32'h40);
        wr(`MEI_REG_MOTION_DURATION_THRESHOLD, 32'd0);
    endtask
    task automatic t_still();
        wr(`MEI_REG_ST_THR, 32'd20);
        wr(`MEI_REG_ST_DUR, 32'd4);
        repeat (60) samp(0, 0, 0);
        rd(DET, 32'h1, 32'h1);
        rd(STA, 32'h20, 32'h20);
        rd(DET, 32'h1, 32'h1);
        samp(1000, 0, 0);
        rd(STA, 32'h20, 32'h20);
        rd(DET, 32'h0, 32'h1);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_sources();
        t_fall();
        t_motion();
        t_still();
        summarize();
    end
endmodule // motion_event_interrupts_bench
bind mei_top mei_top_sva u_mei_top_sva (.*);
